/* core/uart_line_and_modem_status.sv */
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Parity-error flag is line status bit 2, set on bad parity, else 0.
// RQ2 - In FIFO mode parity flag belongs to the character at the FIFO head.
// RQ3 - Overrun flag, line status bit 1, sets when a character lands while full.
// RQ4 - On overrun the shift register is overwritten; FIFO contents stay untouched.
// RQ5 - Data-ready, line status bit 0, high while any received character is held.
// RQ6 - Modem status shares its address with extra-feature control; writes go there.
// RQ7 - Reading modem status clears change bits 3:0.
// RQ8 - Bit 7 is inverted carrier detect, or output-two control bit in loopback.
// RQ9 - Bit 6 is inverted ring indicator, or output-one control bit in loopback.
// RQ10 - Bit 5 is inverted data-set-ready, or data-terminal-ready bit in loopback.
// RQ11 - Bit 4 is inverted clear-to-send, or request-to-send bit in loopback.
// RQ12 - Carrier, data-set-ready and clear-to-send change bits set on either edge.
// RQ13 - Ring change bit sets only when the ring input rises from 0 to 1.
// RQ14 - Modem status interrupt is requested while any change bit is 1.
// RQ15 - FIFO error flag is high while any stored character carries an error.
// RQ16 - A change in the same cycle as the clearing read stays set.
module uart_line_and_modem_status (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  input  wire logic       rx_done,
  input  wire logic [7:0] rx_char,
  input  wire logic       rx_parity_err,
  input  wire logic       rx_framing_err,
  input  wire logic       rx_break,
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ri_n,
  input  wire logic       cd_n,
  output logic            rts_n,
  output logic            dtr_n,
  output logic            out_one_n,
  output logic            out_two_n,
  output logic      [7:0] extra_feature_control,
  output logic            modem_irq,
  output logic            irq
);

  // ****************************************
  // Storage and state
  // ****************************************
  logic [10:0]      fifo_mem [uart_status_pkg::FIFO_DEPTH];
  logic [uart_status_pkg::PTR_W-1:0] wr_ptr;
  logic [uart_status_pkg::PTR_W-1:0] rd_ptr;
  logic [7:0]       count;
  logic [7:0]       err_count;
  logic [7:0]       shift_char;
  logic             overrun;
  logic [7:0]       modem_control;
  logic             fifo_enable;
  logic [3:0]       delta;
  logic [3:0]       pin_prev;
  logic [3:0]       int_status;
  logic [3:0]       int_mask;

  logic [uart_status_pkg::PTR_W-1:0] next_wr_ptr;
  logic [uart_status_pkg::PTR_W-1:0] next_rd_ptr;
  logic [7:0]       next_count;
  logic [7:0]       next_err_count;
  logic [7:0]       next_shift_char;
  logic             next_overrun;
  logic [7:0]       next_modem_control;
  logic             next_fifo_enable;
  logic [7:0]       next_extra;
  logic [3:0]       next_delta;
  logic [3:0]       next_int_status;
  logic [3:0]       next_int_mask;
  logic [7:0]       next_rd_data;
  logic             next_rts_n;
  logic             next_dtr_n;
  logic             next_out_one_n;
  logic             next_out_two_n;
  logic             next_modem_irq;
  logic             next_irq;

  // ****************************************
  // Combinational helpers
  // ****************************************
  logic [7:0]  cap;
  logic        full;
  logic        push;
  logic        pop;
  logic        loopback;
  logic [3:0]  pin_now;
  logic [3:0]  pin_change;
  logic [3:0]  delta_set;
  logic [10:0] head;
  logic [10:0] entry_in;
  logic        entry_err;
  logic        head_err;
  logic [7:0]  line_status;
  logic [7:0]  modem_status;
  logic        rd_line;
  logic        rd_modem;

  assign loopback  = modem_control[uart_status_pkg::MC_LOOPBACK];
  // A disabled FIFO behaves as a one-deep holding register
  assign cap       = fifo_enable ? uart_status_pkg::FIFO_CAP : uart_status_pkg::HOLD_CAP;
  assign full      = (count >= cap);
  assign rd_line   = rd_en && (addr == uart_status_pkg::OFS_LINE_STATUS);
  assign rd_modem  = rd_en && (addr == uart_status_pkg::OFS_MODEM_STATUS);
  assign pop       = rd_en && (addr == uart_status_pkg::OFS_RX_DATA) && (count != 8'h00);
  assign push      = rx_done && !full; // [RQ3] [RQ4]
  assign entry_in  = {rx_break, rx_framing_err, rx_parity_err, rx_char};
  assign entry_err = |entry_in[10:8];
  assign head      = fifo_mem[rd_ptr];
  assign head_err  = |head[10:8];

  // Pin order is cts, dsr, ri, cd; in loopback the pins follow the control bits
  always_comb begin
    if (loopback) begin
      pin_now = ~{modem_control[uart_status_pkg::MC_OUT_TWO],   // [RQ8]
                  modem_control[uart_status_pkg::MC_OUT_ONE],   // [RQ9]
                  modem_control[uart_status_pkg::MC_DTR],       // [RQ10]
                  modem_control[uart_status_pkg::MC_RTS]};      // [RQ11]
    end else begin
      pin_now = {cd_n, ri_n, dsr_n, cts_n};
    end
  end

  // Already in the change-bit layout bit for bit: cd, ri, dsr, cts
  assign pin_change = pin_now ^ pin_prev;
  always_comb begin
    delta_set = 4'h0;
    delta_set[uart_status_pkg::MS_DELTA_CD]  = pin_change[3];  // [RQ12]
    delta_set[uart_status_pkg::MS_DELTA_DSR] = pin_change[1];  // [RQ12]
    delta_set[uart_status_pkg::MS_DELTA_CTS] = pin_change[0];  // [RQ12]
    delta_set[uart_status_pkg::MS_TRAIL_RI]  = pin_now[2] && !pin_prev[2]; // [RQ13]
  end

  always_comb begin
    modem_status = {~pin_now[3], ~pin_now[2], ~pin_now[1], ~pin_now[0], delta};
  end

  always_comb begin
    line_status = 8'h00;
    line_status[uart_status_pkg::LS_DATA_READY] = (count != 8'h00);         // [RQ5]
    line_status[uart_status_pkg::LS_OVERRUN]    = overrun;                  // [RQ3]
    // Error bits describe the oldest stored character, not the newest
    line_status[uart_status_pkg::LS_PARITY]     = (count != 8'h00) && head[8];  // [RQ1] [RQ2]
    line_status[uart_status_pkg::LS_FRAMING]    = (count != 8'h00) && head[9];
    line_status[uart_status_pkg::LS_BREAK]      = (count != 8'h00) && head[10];
    line_status[uart_status_pkg::LS_FIFO_ERROR] = (err_count != 8'h00);     // [RQ15]
  end

  // ****************************************
  // Receive store next state
  // ****************************************
  always_comb begin
    next_wr_ptr     = wr_ptr;
    next_rd_ptr     = rd_ptr;
    next_count      = count;
    next_err_count  = err_count;
    next_shift_char = shift_char;
    next_overrun    = overrun;
    if (rx_done) begin
      // Shift register always takes the newest character, even when it is lost
      next_shift_char = rx_char;  // [RQ4]
    end
    if (push) begin
      next_wr_ptr = wr_ptr + 7'h01;
    end
    if (pop) begin
      next_rd_ptr = rd_ptr + 7'h01;
    end
    if (push && !pop) begin
      next_count = count + 8'h01;
    end else if (pop && !push) begin
      next_count = count - 8'h01;
    end
    if ((push && entry_err) && !(pop && head_err)) begin
      next_err_count = err_count + 8'h01;  // [RQ15]
    end else if (!(push && entry_err) && (pop && head_err)) begin
      next_err_count = err_count - 8'h01;  // [RQ15]
    end
    // Read clears overrun, but a new overrun in the same cycle wins
    if (rd_line) begin
      next_overrun = 1'b0;
    end
    if (rx_done && full) begin
      next_overrun = 1'b1;  // [RQ3]
    end
    // Switching FIFO mode flushes the store, as the capacity changes under it
    if (wr_en && addr == uart_status_pkg::OFS_FIFO_CONTROL &&
        wr_data[uart_status_pkg::FC_FIFO_ENABLE] != fifo_enable) begin
      next_wr_ptr    = 7'h00;
      next_rd_ptr    = 7'h00;
      next_count     = 8'h00;
      next_err_count = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      fifo_mem[wr_ptr] <= entry_in;  // [RQ4]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr     <= 7'h00;
      rd_ptr     <= 7'h00;
      count      <= 8'h00;
      err_count  <= 8'h00;
      shift_char <= 8'h00;
      overrun    <= 1'b0;
    end else begin
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      count      <= next_count;
      err_count  <= next_err_count;
      shift_char <= next_shift_char;
      overrun    <= next_overrun;
    end
  end

  // ****************************************
  // Control registers and modem change bits
  // ****************************************
  always_comb begin
    next_modem_control = modem_control;
    next_fifo_enable   = fifo_enable;
    next_extra         = extra_feature_control;
    next_int_mask      = int_mask;
    next_delta         = delta;
    next_int_status    = int_status;
    if (wr_en) begin
      unique case (addr)
        uart_status_pkg::OFS_MODEM_STATUS:  next_extra = wr_data;  // [RQ6]
        uart_status_pkg::OFS_MODEM_CONTROL: next_modem_control = {3'h0, wr_data[4:0]};
        uart_status_pkg::OFS_FIFO_CONTROL:
          next_fifo_enable = wr_data[uart_status_pkg::FC_FIFO_ENABLE];
        uart_status_pkg::OFS_INT_STATUS:    next_int_status = int_status & ~wr_data[3:0];
        uart_status_pkg::OFS_INT_MASK:      next_int_mask = wr_data[3:0];
        default: ;
      endcase
    end
    if (rd_modem) begin
      next_delta = 4'h0;  // [RQ7]
    end
    // Set after clear so a change coinciding with the read survives
    next_delta = next_delta | delta_set;  // [RQ16]
    next_int_status[uart_status_pkg::IS_DATA_READY] =
      next_int_status[uart_status_pkg::IS_DATA_READY] | push;
    next_int_status[uart_status_pkg::IS_OVERRUN] =
      next_int_status[uart_status_pkg::IS_OVERRUN] | (rx_done && full);
    next_int_status[uart_status_pkg::IS_PARITY] =
      next_int_status[uart_status_pkg::IS_PARITY] | (push && rx_parity_err);
    next_int_status[uart_status_pkg::IS_MODEM] =
      next_int_status[uart_status_pkg::IS_MODEM] | (|delta_set);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      modem_control         <= uart_status_pkg::RST_MODEM_CONTROL;
      fifo_enable           <= uart_status_pkg::RST_FIFO_ENABLE;
      extra_feature_control <= uart_status_pkg::RST_EXTRA_FEATURE;
      int_mask              <= uart_status_pkg::RST_INT_MASK;
      int_status            <= 4'h0;
      delta                 <= 4'h0;
      pin_prev              <= 4'hF;
    end else begin
      modem_control         <= next_modem_control;
      fifo_enable           <= next_fifo_enable;
      extra_feature_control <= next_extra;
      int_mask              <= next_int_mask;
      int_status            <= next_int_status;
      delta                 <= next_delta;
      pin_prev              <= pin_now;
    end
  end

  // ****************************************
  // Read data and pin outputs
  // ****************************************
  always_comb begin
    next_rd_data = 8'h00;
    if (rd_en) begin
      unique case (addr)
        uart_status_pkg::OFS_RX_DATA:       next_rd_data = (count != 8'h00) ? head[7:0] : 8'h00;
        uart_status_pkg::OFS_LINE_STATUS:   next_rd_data = line_status;
        uart_status_pkg::OFS_MODEM_STATUS:  next_rd_data = modem_status;  // [RQ6]
        uart_status_pkg::OFS_MODEM_CONTROL: next_rd_data = modem_control;
        uart_status_pkg::OFS_FIFO_CONTROL:  next_rd_data = {7'h00, fifo_enable};
        uart_status_pkg::OFS_INT_STATUS:    next_rd_data = {4'h0, int_status};
        uart_status_pkg::OFS_INT_MASK:      next_rd_data = {4'h0, int_mask};
        default:                            next_rd_data = 8'h00;
      endcase
    end
  end

  always_comb begin
    // In loopback the modem outputs are parked inactive; use the next mode so
    // entering loopback never drives the pins active for one cycle
    next_rts_n     = next_modem_control[uart_status_pkg::MC_LOOPBACK] |
                     ~next_modem_control[uart_status_pkg::MC_RTS];
    next_dtr_n     = next_modem_control[uart_status_pkg::MC_LOOPBACK] |
                     ~next_modem_control[uart_status_pkg::MC_DTR];
    next_out_one_n = next_modem_control[uart_status_pkg::MC_LOOPBACK] |
                     ~next_modem_control[uart_status_pkg::MC_OUT_ONE];
    next_out_two_n = next_modem_control[uart_status_pkg::MC_LOOPBACK] |
                     ~next_modem_control[uart_status_pkg::MC_OUT_TWO];
    next_modem_irq = |next_delta;  // [RQ14]
    next_irq       = |(next_int_status & next_int_mask);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data   <= 8'h00;
      rts_n     <= 1'b1;
      dtr_n     <= 1'b1;
      out_one_n <= 1'b1;
      out_two_n <= 1'b1;
      modem_irq <= 1'b0;
      irq       <= 1'b0;
    end else begin
      rd_data   <= next_rd_data;
      rts_n     <= next_rts_n;
      dtr_n     <= next_dtr_n;
      out_one_n <= next_out_one_n;
      out_two_n <= next_out_two_n;
      modem_irq <= next_modem_irq;
      irq       <= next_irq;
    end
  end

endmodule

/* core/uart_status_pkg.sv */
package uart_status_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [2:0] OFS_RX_DATA       = 3'h0;
  localparam logic [2:0] OFS_LINE_STATUS   = 3'h1;
  localparam logic [2:0] OFS_MODEM_STATUS  = 3'h2;
  localparam logic [2:0] OFS_MODEM_CONTROL = 3'h3;
  localparam logic [2:0] OFS_FIFO_CONTROL  = 3'h4;
  localparam logic [2:0] OFS_INT_STATUS    = 3'h5;
  localparam logic [2:0] OFS_INT_MASK      = 3'h6;

  // ****************************************
  // Line status fields
  // ****************************************
  localparam int LS_DATA_READY  = 0;
  localparam int LS_OVERRUN     = 1;
  localparam int LS_PARITY      = 2;
  localparam int LS_FRAMING     = 3;
  localparam int LS_BREAK       = 4;
  localparam int LS_FIFO_ERROR  = 7;

  // ****************************************
  // Modem status / control fields
  // ****************************************
  localparam int MS_DELTA_CTS   = 0;
  localparam int MS_DELTA_DSR   = 1;
  localparam int MS_TRAIL_RI    = 2;
  localparam int MS_DELTA_CD    = 3;
  localparam int MS_LEVEL_LO    = 4;
  localparam int MC_DTR         = 0;
  localparam int MC_RTS         = 1;
  localparam int MC_OUT_ONE     = 2;
  localparam int MC_OUT_TWO     = 3;
  localparam int MC_LOOPBACK    = 4;
  localparam int FC_FIFO_ENABLE = 0;

  // ****************************************
  // Interrupt status fields
  // ****************************************
  localparam int IS_DATA_READY  = 0;
  localparam int IS_OVERRUN     = 1;
  localparam int IS_PARITY      = 2;
  localparam int IS_MODEM       = 3;

  // ****************************************
  // Reset values and sizes
  // ****************************************
  localparam logic [7:0] RST_MODEM_CONTROL = 8'h00;
  localparam logic [7:0] RST_EXTRA_FEATURE = 8'h00;
  localparam logic [0:0] RST_FIFO_ENABLE   = 1'h0;
  localparam logic [3:0] RST_INT_MASK      = 4'h0;
  localparam int         FIFO_DEPTH        = 128;
  localparam int         PTR_W             = 7;
  localparam logic [7:0] FIFO_CAP          = 8'h80;
  localparam logic [7:0] HOLD_CAP          = 8'h01;

endpackage

/* verification/modem_peer.sv */
`timescale 1ns/1ps
// ****************************************
// Modem side of the status lines
// ****************************************
module modem_peer (
  input  wire logic       clk,
  input  wire logic [3:0] want,
  input  wire logic       slow,
  output logic            cd_n,
  output logic            ri_n,
  output logic            dsr_n,
  output logic            cts_n
);
  logic [3:0] held;
  // Idle lines sit high, as an unplugged modem leaves them
  initial {held, cd_n, ri_n, dsr_n, cts_n} = 8'hFF;
  // A slow modem settles one clock later than a prompt one
  always @(posedge clk) begin
    held <= want;
    {cd_n, ri_n, dsr_n, cts_n} <= slow ? held : want;
  end
endmodule

/* verification/uart_status_asserts.sv */
`timescale 1ns/1ps
// ****************************************
// Status port checks
// ****************************************
module uart_status_checker (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  input wire logic       rx_done,
  input wire logic       cts_n,
  input wire logic       dsr_n,
  input wire logic       ri_n,
  input wire logic       cd_n,
  input wire logic       rts_n,
  input wire logic       dtr_n,
  input wire logic       out_one_n,
  input wire logic       out_two_n,
  input wire logic [7:0] extra_feature_control,
  input wire logic       modem_irq
);
  wire logic [3:0] pins = {cd_n, ri_n, dsr_n, cts_n};
  wire logic [3:0] outs = {out_two_n, out_one_n, dtr_n, rts_n};
  // Loopback parks all modem outputs high, so one low output proves normal mode
  wire logic       norm = ~&outs;
  wire logic       ms_rd = rd_en && addr == uart_status_pkg::OFS_MODEM_STATUS;
  wire logic       ms_wr = wr_en && addr == uart_status_pkg::OFS_MODEM_STATUS;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_levels_follow: assert property (
    ms_rd && norm && $stable(pins) && $past(nrst) |=> rd_data[7:4] == ~$past(pins))
    else $error("level bits differ from inputs");
  a_change_raises: assert property (
    norm && $stable(outs) && $changed({cd_n, dsr_n, cts_n}) |=> modem_irq)
    else $error("toggle set no change bit");
  a_ring_rise: assert property (
    norm && $stable(outs) && $rose(ri_n) |=> modem_irq)
    else $error("ring rise set no change bit");
  a_read_clears: assert property (
    ms_rd && norm && $stable(outs) && $stable({cd_n, dsr_n, cts_n}) && !$rose(ri_n)
      && $past(nrst) |=> !modem_irq)
    else $error("change bits survived a read");
  a_irq_mirrors: assert property (
    ms_rd |=> (rd_data[3:0] != 4'h0) == $past(modem_irq))
    else $error("modem interrupt disagrees with change bits");
  a_efc_write: assert property (
    ms_wr |=> extra_feature_control == $past(wr_data))
    else $error("extra feature write lost");
  a_efc_hold: assert property (
    !ms_wr |=> $stable(extra_feature_control))
    else $error("extra feature changed unwritten");
  a_ready_after_rx: assert property (
    (rx_done && !rd_en && !wr_en) ##1 (!rd_en && !wr_en)
      ##1 (rd_en && addr == uart_status_pkg::OFS_LINE_STATUS)
      |=> rd_data[0])
    else $error("data ready low after receive");
endmodule
bind uart_line_and_modem_status uart_status_checker chk (
  .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .rx_done(rx_done), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
  .cd_n(cd_n), .rts_n(rts_n), .dtr_n(dtr_n), .out_one_n(out_one_n), .out_two_n(out_two_n),
  .extra_feature_control(extra_feature_control), .modem_irq(modem_irq)
);

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        clk, nrst, wr_en, rd_en, rx_done, slow, ovr;
  logic        rx_parity_err, rx_framing_err, rx_break, rts_n, dtr_n, out_one_n, out_two_n;
  logic        cts_n, dsr_n, ri_n, cd_n, modem_irq, irq;
  logic [2:0]  addr;
  logic [7:0]  wr_data, rx_char, rd_data, extra_feature_control, v, r8;
  logic [3:0]  want, prev, delta, r;
  logic [10:0] q[$];
  int          cap, n_fail, check_count;
  uart_line_and_modem_status dut (.clk, .nrst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .rx_done, .rx_char, .rx_parity_err, .rx_framing_err, .rx_break, .cts_n, .dsr_n, .ri_n,
    .cd_n, .rts_n, .dtr_n, .out_one_n, .out_two_n, .extra_feature_control, .modem_irq, .irq);
  modem_peer peer (.clk, .want, .slow, .cd_n, .ri_n, .dsr_n, .cts_n);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****************************************
  // Bus, receive and compare helpers
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
    @(posedge clk);
  endtask
  task automatic rx(input logic [10:0] c);
    {rx_break, rx_framing_err, rx_parity_err, rx_char} <= c;
    rx_done <= 1'b1;
    @(posedge clk);
    rx_done <= 1'b0;
    @(posedge clk);
    if (q.size() < cap) q.push_back(c);
    else ovr = 1'b1;
  endtask
  // Pops one character, checking the flags of the head first
  task automatic drain_one();
    logic [10:0] h;
    logic        any;
    h = (q.size() != 0) ? q[0] : 11'h000;
    any = 1'b0;
    foreach (q[j]) any |= |q[j][10:8];
    rd(uart_status_pkg::OFS_LINE_STATUS);
    check("line status", v, {any, 2'h0, h[10:8], ovr, q.size() != 0});
    ovr = 1'b0;
    rd(uart_status_pkg::OFS_RX_DATA);
    check("rx data", v, h[7:0]);
    if (q.size() != 0) void'(q.pop_front());
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {nrst, wr_en, rd_en, rx_done, slow, ovr} = 6'h00;
    {addr, wr_data, rx_char, rx_parity_err, rx_framing_err, rx_break} = 22'h0;
    {want, prev, delta} = 12'hFF0;
    {cap, n_fail, check_count} = {32'd1, 32'd0, 32'd0};
    void'($urandom(1));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      check("reset read", v, 8'h00);
    end
    wr(3'h7, 8'hFF);
    rd(3'h7);
    check("unmapped", v, 8'h00);
    wr(uart_status_pkg::OFS_MODEM_CONTROL, 8'h01);
    for (int i = 0; i < 40; i++) begin
      want <= 4'($urandom);
      slow <= 1'($urandom);
      @(posedge clk);
      // Every fourth pass reads early; with a prompt modem the read lands in the cycle the change is detected
      if (i % 4 == 0) begin
        rd(uart_status_pkg::OFS_MODEM_STATUS);
        check("early delta", {4'h0, v[3:0]}, {4'h0, delta});
        delta = 4'h0;
      end
      repeat (3) @(posedge clk);
      delta |= ((prev ^ want) & 4'hB) | (want & ~prev & 4'h4);
      prev = want;
      check("modem irq", {7'h0, modem_irq}, {7'h0, |delta});
      rd(uart_status_pkg::OFS_MODEM_STATUS);
      check("modem status", v, {~want, delta});
      delta = 4'h0;
    end
    for (int i = 0; i < 6; i++) begin
      r = 4'($urandom);
      wr(uart_status_pkg::OFS_MODEM_CONTROL, {4'hF, r});
      rd(uart_status_pkg::OFS_MODEM_STATUS);
      rd(uart_status_pkg::OFS_MODEM_STATUS);
      check("loop status", v, {r[3], r[2], r[0], r[1], 4'h0});
      rd(uart_status_pkg::OFS_MODEM_CONTROL);
      check("modem control", v, {4'h1, r});
      check("loop pins", {4'h0, dtr_n, rts_n, out_one_n, out_two_n}, 8'h0F);
    end
    wr(uart_status_pkg::OFS_MODEM_CONTROL, 8'h01);
    check("modem pins", {4'h0, dtr_n, rts_n, out_one_n, out_two_n}, 8'h07);
    rd(uart_status_pkg::OFS_MODEM_STATUS);
    r8 = 8'($urandom);
    wr(uart_status_pkg::OFS_MODEM_STATUS, r8);
    check("extra feature", extra_feature_control, r8);
    rd(uart_status_pkg::OFS_MODEM_STATUS);
    check("shared address", v, {~want, 4'h0});
    rx(11'h1C3);
    rx(11'h03C);
    drain_one();
    drain_one();
    wr(uart_status_pkg::OFS_FIFO_CONTROL, 8'h01);
    cap = 128;
    for (int i = 0; i < 129; i++) rx({(i < 110) ? 3'($urandom) & 3'($urandom) : 3'h0, 8'($urandom)});
    repeat (130) drain_one();
    wr(uart_status_pkg::OFS_INT_STATUS, 8'h0F);
    wr(uart_status_pkg::OFS_INT_MASK, 8'hFF);
    rd(uart_status_pkg::OFS_INT_MASK);
    check("int mask", v, 8'h0F);
    rx(11'h0A5);
    check("data irq", {7'h0, irq}, 8'h01);
    wr(uart_status_pkg::OFS_INT_MASK, 8'h08);
    check("masked irq", {7'h0, irq}, 8'h00);
    want <= want ^ 4'h1;
    repeat (4) @(posedge clk);
    check("modem irq on", {6'h0, irq, modem_irq}, 8'h03);
    rd(uart_status_pkg::OFS_MODEM_STATUS);
    wr(uart_status_pkg::OFS_INT_STATUS, 8'h0F);
    check("irq cleared", {6'h0, irq, modem_irq}, 8'h00);
    tally_and_finish();
  end
endmodule
